// File: verilog/ahp_pkg.sv
// Constants and types shared by the serial host port files
package ahp_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int SC_DIV = 8;
  localparam int SC_HALF = SC_DIV / 2;
  localparam int SC_LEAD_CYC = 29;
  localparam int SC_STALL_HIGH = 28;
  localparam int SC_RISE_RISE = 32;
  localparam int BYTE_BITS = 8;
  // The idle exit and the clock output register eat two of the lead cycles
  localparam logic [5:0] SC_LEAD_LEN = 6'(SC_LEAD_CYC - 3);
  localparam logic [5:0] SC_STALL_LEN = 6'(SC_STALL_HIGH - SC_HALF);
  localparam logic [5:0] SC_BURST_LAST = 6'(SC_DIV * BYTE_BITS - 1);
  localparam int IB_DIR_BIT = 7;
  localparam int IB_CNT_HI = 6;
  localparam int IB_CNT_LO = 5;
  localparam int IB_FSC_BIT = 4;
  localparam int IB_REG_HI = 3;
  localparam int IB_REG_LO = 2;
  localparam int IB_BYTE_HI = 1;
  localparam int IB_BYTE_LO = 0;
  localparam logic [1:0] SEL_RESULT = 2'h0;
  localparam logic [1:0] SEL_CTRL = 2'h1;
  localparam logic [1:0] SEL_OFFSET = 2'h2;
  localparam logic [1:0] SEL_SPAN = 2'h3;
  localparam int NUM_REGS = 5;
  localparam logic [2:0] IDX_RESULT = 3'h0;
  localparam logic [2:0] IDX_CTRL = 3'h1;
  localparam logic [2:0] IDX_OFFSET = 3'h2;
  localparam logic [2:0] IDX_POS = 3'h3;
  localparam logic [2:0] IDX_NEG = 3'h4;
  localparam logic [1:0] BYTE_LAST = 2'h2;
  localparam int CR_THREE_WIRE_BIT = 0;
  localparam int CR_LSB_FIRST_BIT = 1;
  localparam int CR_BYTE_ASC_BIT = 2;
  localparam logic [23:0] RST_RESULT = 24'h00_0000;
  localparam logic [23:0] RST_CTRL = 24'h00_0000;
  localparam logic [23:0] RST_OFFSET = 24'h00_0000;
  localparam logic [23:0] RST_POS = 24'h80_0000;
  localparam logic [23:0] RST_NEG = 24'h80_0000;
  localparam logic [23:0] RST_VALS [NUM_REGS] = '{RST_RESULT, RST_CTRL, RST_OFFSET, RST_POS,
                                                   RST_NEG};
  typedef enum logic [1:0] {PH_INSTR = 2'b01, PH_DATA = 2'b10} ahp_phase_t;
  typedef enum logic [3:0] {
    SC_IDLE = 4'b0001, SC_LEAD = 4'b0010, SC_BURST = 4'b0100, SC_STALL = 4'b1000
  } ahp_sc_state_t;
endpackage : ahp_pkg

// File: verilog/ahp_sclk_gen.sv
// Self-clocking shift clock generator with byte stalls
`timescale 1ns/1ps
module ahp_sclk_gen (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic cs_n_i,
  output logic sclk_o,
  output logic fall_o,
  output logic rise_o,
  output logic burst_o
);
  import ahp_pkg::*;
  ahp_sc_state_t state_ff;
  logic [5:0] cnt_ff;
  logic cs_q_ff;

  // Chip select is only looked at after one register of latency
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) cs_q_ff <= 1'b1;
    else cs_q_ff <= cs_n_i;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_ff <= SC_IDLE;
      cnt_ff <= 6'h00;
    end else begin
      unique case (state_ff)
        SC_IDLE: begin
          cnt_ff <= 6'h00;
          if (enable_i && !cs_q_ff) state_ff <= SC_LEAD;
        end
        SC_LEAD: begin
          cnt_ff <= (cnt_ff == SC_LEAD_LEN) ? 6'h00 : cnt_ff + 6'h01;
          if (cnt_ff == SC_LEAD_LEN) state_ff <= SC_BURST;
        end
        SC_BURST: begin
          // A started byte always runs to its end, whatever chip select does
          cnt_ff <= (cnt_ff == SC_BURST_LAST) ? 6'h00 : cnt_ff + 6'h01;
          if (cnt_ff == SC_BURST_LAST) state_ff <= SC_STALL;
        end
        SC_STALL: begin
          cnt_ff <= (cnt_ff == SC_STALL_LEN - 6'h01) ? 6'h00 : cnt_ff + 6'h01;
          if (cnt_ff == SC_STALL_LEN - 6'h01) begin
            state_ff <= (enable_i && !cs_q_ff) ? SC_BURST : SC_IDLE;
          end
        end
      endcase
    end
  end

  // Clock is high everywhere outside the low halves of a burst
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sclk_o <= 1'b1;
      fall_o <= 1'b0;
      rise_o <= 1'b0;
      burst_o <= 1'b0;
    end else begin
      sclk_o <= (state_ff == SC_BURST) ? cnt_ff[2] : 1'b1;
      fall_o <= (state_ff == SC_BURST) && (cnt_ff[2:0] == 3'h0);
      rise_o <= (state_ff == SC_BURST) && (cnt_ff[2:0] == 3'h4);
      burst_o <= (state_ff == SC_BURST);
    end
  end

  lead_delay_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state_ff == SC_IDLE && enable_i && !cs_q_ff) |-> ##29 $fell(sclk_o))
    else $error("first shift clock edge not 29 cycles after select");
  stall_high_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state_ff == SC_STALL || state_ff == SC_IDLE) |=> sclk_o)
    else $error("shift clock low during a stall");
  rise_gap_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (rise_o && state_ff == SC_BURST && cnt_ff == 6'h3d)
    |-> ##32 (rise_o || state_ff != SC_BURST))
    else $error("rise gap broken");
  burst_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state_ff == SC_BURST && cnt_ff == 6'h00) |-> ##64 (state_ff == SC_STALL))
    else $error("burst is not eight shift clock periods");
  boundary_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state_ff == SC_STALL && cnt_ff == 6'h00 && enable_i && !cs_n_i && !cs_q_ff)
    |-> ##24 (state_ff == SC_BURST || cs_q_ff))
    else $error("byte stall length wrong");
endmodule : ahp_sclk_gen

// File: verilog/ahp_reg_bank.sv
// Five 24-bit port registers with byte access
`timescale 1ns/1ps
module ahp_reg_bank (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [23:0] result_i,
  input wire logic result_load_i,
  input wire logic wr_en_i,
  input wire logic [2:0] wr_idx_i,
  input wire logic [1:0] wr_byte_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [2:0] rd_idx_i,
  input wire logic [1:0] rd_byte_i,
  output logic [7:0] rd_data_o,
  output logic [23:0] result_o,
  output logic [23:0] ctrl_o,
  output logic [23:0] offset_o,
  output logic [23:0] pos_span_o,
  output logic [23:0] neg_span_o
);
  import ahp_pkg::*;
  logic [23:0] regs_ff [NUM_REGS];

  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        regs_ff[g] <= RST_VALS[g];
      end else if (3'(g) == IDX_RESULT) begin
        if (result_load_i) regs_ff[g] <= result_i;
      end else if (wr_en_i && wr_idx_i == 3'(g) && wr_byte_i <= BYTE_LAST) begin
        regs_ff[g][8 * wr_byte_i +: 8] <= wr_data_i;
      end
    end
  end

  // Byte address 3 and unused register codes read as zero
  always_comb begin
    rd_data_o = 8'h00;
    if (rd_idx_i < 3'(NUM_REGS) && rd_byte_i <= BYTE_LAST) begin
      rd_data_o = regs_ff[rd_idx_i][8 * rd_byte_i +: 8];
    end
  end

  assign result_o = regs_ff[IDX_RESULT];
  assign ctrl_o = regs_ff[IDX_CTRL];
  assign offset_o = regs_ff[IDX_OFFSET];
  assign pos_span_o = regs_ff[IDX_POS];
  assign neg_span_o = regs_ff[IDX_NEG];
endmodule : ahp_reg_bank

// File: verilog/ahp_host_port.sv
// Serial host port: instruction decode, byte shifter and pin control
`timescale 1ns/1ps
module ahp_host_port (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic mode_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_n_o,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n_o,
  output logic serial_output_line_o,
  output logic serial_output_line_oe_n_o,
  output logic data_ready_n_o,
  input wire logic [23:0] result_i,
  input wire logic result_load_i,
  output logic [23:0] ctrl_o,
  output logic [23:0] offset_o,
  output logic [23:0] pos_span_o,
  output logic [23:0] neg_span_o
);
  import ahp_pkg::*;

  logic mode_ff;
  logic sclk_q_ff;
  logic sclk_oe_n_ff;
  ahp_phase_t phase_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shreg_ff;
  logic [7:0] instr_ff;
  logic [1:0] bytes_left_ff;
  logic [1:0] byte_sel_ff;
  logic [2:0] cur_idx_ff;
  logic [7:0] out_byte_ff;
  logic dout_ff;
  logic sdo_oe_n_ff;
  logic sdio_oe_n_ff;
  logic ready_n_ff;

  logic sc_sclk;
  logic sc_fall;
  logic sc_rise;
  logic sc_burst;
  logic ext_rise;
  logic ext_fall;
  logic rise;
  logic fall;
  logic msb_first;
  logic byte_asc;
  logic three_wire;
  logic [7:0] rx_byte;
  logic byte_done;
  logic is_read;
  logic drive;
  logic [1:0] nxt_sel;
  logic [2:0] rx_idx;
  logic [2:0] rd_idx;
  logic [1:0] rd_byte;
  logic [7:0] rd_data;
  logic wr_en;
  logic [23:0] result_q;
  logic result_read_done;

  // Register address and field decode
  function automatic logic [2:0] reg_index(input logic [1:0] sel, input logic span_register_select);
    logic [2:0] idx;
    idx = IDX_RESULT;
    unique case (sel)
      SEL_RESULT: idx = IDX_RESULT;
      SEL_CTRL: idx = IDX_CTRL;
      SEL_OFFSET: idx = IDX_OFFSET;
      SEL_SPAN: idx = span_register_select ? IDX_NEG : IDX_POS;
    endcase
    return idx;
  endfunction : reg_index

  // Byte walk wraps inside the three bytes of a register
  function automatic logic [1:0] step_byte(input logic [1:0] sel, input logic asc);
    logic [1:0] nxt;
    if (asc) nxt = (sel >= BYTE_LAST) ? 2'h0 : sel + 2'h1;
    else nxt = (sel == 2'h0 || sel > BYTE_LAST) ? BYTE_LAST : sel - 2'h1;
    return nxt;
  endfunction : step_byte

  ahp_sclk_gen u_sclk_gen (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .enable_i(mode_ff),
    .cs_n_i(cs_n_i),
    .sclk_o(sc_sclk),
    .fall_o(sc_fall),
    .rise_o(sc_rise),
    .burst_o(sc_burst)
  );

  ahp_reg_bank u_reg_bank (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .result_i(result_i),
    .result_load_i(result_load_i),
    .wr_en_i(wr_en),
    .wr_idx_i(cur_idx_ff),
    .wr_byte_i(byte_sel_ff),
    .wr_data_i(rx_byte),
    .rd_idx_i(rd_idx),
    .rd_byte_i(rd_byte),
    .rd_data_o(rd_data),
    .result_o(result_q),
    .ctrl_o(ctrl_o),
    .offset_o(offset_o),
    .pos_span_o(pos_span_o),
    .neg_span_o(neg_span_o)
  );

  // Mode pin may move only while the port is idle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_ff <= 1'b0;
      sclk_oe_n_ff <= 1'b1;
    end else begin
      mode_ff <= mode_i;
      sclk_oe_n_ff <= ~mode_i;
    end
  end

  // Previous level tracked while deselected, so no false edge on resume
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) sclk_q_ff <= 1'b1;
    else sclk_q_ff <= sclk_i;
  end

  assign ext_rise = !mode_ff && !cs_n_i && sclk_i && !sclk_q_ff;
  assign ext_fall = !mode_ff && !cs_n_i && !sclk_i && sclk_q_ff;
  assign rise = mode_ff ? sc_rise : ext_rise;
  assign fall = mode_ff ? sc_fall : ext_fall;

  assign msb_first = ~ctrl_o[CR_LSB_FIRST_BIT];
  assign byte_asc = ctrl_o[CR_BYTE_ASC_BIT];
  assign three_wire = ctrl_o[CR_THREE_WIRE_BIT];

  // Host data always arrives on the shared line
  assign rx_byte = msb_first ? {shreg_ff[6:0], sdio_i} : {sdio_i, shreg_ff[7:1]};
  assign byte_done = rise && (bit_cnt_ff == 3'h7);
  assign is_read = (phase_ff == PH_DATA) && !instr_ff[IB_DIR_BIT];
  assign nxt_sel = step_byte(byte_sel_ff, byte_asc);
  assign rx_idx = reg_index(rx_byte[IB_REG_HI:IB_REG_LO], rx_byte[IB_FSC_BIT]);
  assign rd_idx = (phase_ff == PH_INSTR) ? rx_idx : cur_idx_ff;
  assign rd_byte = (phase_ff == PH_INSTR) ? rx_byte[IB_BYTE_HI:IB_BYTE_LO] : nxt_sel;
  assign wr_en = byte_done && (phase_ff == PH_DATA) && instr_ff[IB_DIR_BIT];
  assign result_read_done = byte_done && is_read && (bytes_left_ff == 2'h0)
                            && (cur_idx_ff == IDX_RESULT)
                            && (instr_ff[IB_CNT_HI:IB_CNT_LO] >= BYTE_LAST);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      shreg_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
    end else if (rise) begin
      shreg_ff <= rx_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  // Cycle sequencer; a pause between bytes keeps the remaining count
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      phase_ff <= PH_INSTR;
      instr_ff <= 8'h00;
      bytes_left_ff <= 2'h0;
      byte_sel_ff <= 2'h0;
      cur_idx_ff <= IDX_RESULT;
      out_byte_ff <= 8'h00;
    end else if (byte_done) begin
      unique case (phase_ff)
        PH_INSTR: begin
          phase_ff <= PH_DATA;
          instr_ff <= rx_byte;
          bytes_left_ff <= rx_byte[IB_CNT_HI:IB_CNT_LO];
          byte_sel_ff <= rx_byte[IB_BYTE_HI:IB_BYTE_LO];
          cur_idx_ff <= rx_idx;
          out_byte_ff <= rd_data;
        end
        PH_DATA: begin
          if (bytes_left_ff == 2'h0) begin
            phase_ff <= PH_INSTR;
          end else begin
            bytes_left_ff <= bytes_left_ff - 2'h1;
            byte_sel_ff <= nxt_sel;
            out_byte_ff <= rd_data;
          end
        end
      endcase
    end
  end

  // Read data changes on the falling edge, ahead of the host sample
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dout_ff <= 1'b0;
    end else if (fall) begin
      dout_ff <= msb_first ? out_byte_ff[~bit_cnt_ff] : out_byte_ff[bit_cnt_ff];
    end
  end

  // Self mode keeps driving through a started byte
  assign drive = is_read && (mode_ff ? (!cs_n_i || sc_burst) : !cs_n_i);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sdo_oe_n_ff <= 1'b1;
      sdio_oe_n_ff <= 1'b1;
    end else begin
      sdo_oe_n_ff <= ~(drive && three_wire);
      sdio_oe_n_ff <= ~(drive && !three_wire);
    end
  end

  // A new result wins over a finishing read in the same cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) ready_n_ff <= 1'b1;
    else if (result_load_i) ready_n_ff <= 1'b0;
    else if (result_read_done) ready_n_ff <= 1'b1;
  end

  assign sclk_o = sc_sclk;
  assign sclk_oe_n_o = sclk_oe_n_ff;
  assign sdio_o = dout_ff;
  assign sdio_oe_n_o = sdio_oe_n_ff;
  assign serial_output_line_o = dout_ff;
  assign serial_output_line_oe_n_o = sdo_oe_n_ff;
  assign data_ready_n_o = ready_n_ff;

  ext_freeze_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!mode_ff && cs_n_i) |=> ($stable(bit_cnt_ff) && $stable(phase_ff)
                              && $stable(bytes_left_ff)))
    else $error("port state moved while deselected");
  ext_float_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!mode_ff && cs_n_i) |=> (sdio_oe_n_o && serial_output_line_oe_n_o))
    else $error("outputs driven while deselected in external mode");
  stall_float_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_ff && cs_n_i && !sc_burst) |=> (sdio_oe_n_o && serial_output_line_oe_n_o))
    else $error("outputs not disabled one cycle after stall deselect");
  burst_drive_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_ff && is_read && sc_burst && !byte_done && three_wire)
    |=> !serial_output_line_oe_n_o)
    else $error("read output dropped inside a byte");
  one_driver_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !(!sdio_oe_n_o && !serial_output_line_oe_n_o))
    else $error("both data lines driven");
  count_load_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (byte_done && phase_ff == PH_INSTR)
    |=> (bytes_left_ff == $past(rx_byte[IB_CNT_HI:IB_CNT_LO]) && phase_ff == PH_DATA))
    else $error("byte count not taken from instruction");
  read_dir_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (byte_done && phase_ff == PH_INSTR && !rx_byte[IB_DIR_BIT]) |=> is_read)
    else $error("read direction not decoded");
  result_ro_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && cur_idx_ff == IDX_RESULT && !result_load_i) |=> $stable(result_q))
    else $error("result register changed by a write");
  ctrl_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && cur_idx_ff == IDX_CTRL && byte_sel_ff == 2'h0) |=> (ctrl_o[7:0] == $past(rx_byte)))
    else $error("setup register byte not written");
  ready_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (result_read_done && !result_load_i) |=> data_ready_n_o)
    else $error("ready flag not cleared after result read");
  ready_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    result_load_i |=> !data_ready_n_o)
    else $error("ready flag not set by new result");

  read_cycle_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    result_read_done);
  write_cycle_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && cur_idx_ff == IDX_CTRL));
  self_pause_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_ff && phase_ff == PH_DATA && cs_n_i && !sc_burst));
  ext_pause_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    (!mode_ff && phase_ff == PH_DATA && cs_n_i) ##1 !cs_n_i);
endmodule : ahp_host_port

// File: tb/ahp_host_model.sv
// Host side serial port model: shift clock and write data
`timescale 1ns/1ps
module ahp_host_model (
  input wire logic clk_i,
  input wire logic mode_i,
  input wire logic three_wire_i,
  input wire logic dev_sclk_i,
  input wire logic dev_data_i,
  input wire logic dev_data_oe_n_i,
  input wire logic sol_i,
  input wire logic sol_oe_n_i,
  output logic sclk_o,
  output logic sdio_o
);
  logic host_drive = 1'b0;
  logic host_bit = 1'b0;
  logic last_bit = 1'b0;
  logic rd_line;
  initial sclk_o = 1'b1;
  // Released line shows a changing pattern, never a stale copy
  always_comb begin
    if (!dev_data_oe_n_i) begin
      sdio_o = dev_data_i;
    end else if (host_drive) begin
      sdio_o = host_bit;
    end else begin
      sdio_o = ~last_bit;
    end
    rd_line = three_wire_i ? (sol_oe_n_i ? ~last_bit : sol_i) : sdio_o;
  end
  always_ff @(posedge clk_i) begin
    last_bit <= sdio_o;
  end
  task automatic wait_dev(input logic lvl);
    int n;
    n = 0;
    while (dev_sclk_i !== lvl && n < 200) begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask : wait_dev
  // One byte in wire order; data changes on the fall, is read on the rise
  task automatic xfer_byte(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (mode_i) begin
        wait_dev(1'b0);
      end else begin
        @(posedge clk_i);
        #1 sclk_o = 1'b0;
      end
      host_drive = drive;
      host_bit = tx[i];
      if (mode_i) begin
        wait_dev(1'b1);
      end else begin
        repeat (3) @(posedge clk_i);
        #1;
      end
      rx[i] = rd_line;
      if (!mode_i) begin
        sclk_o = 1'b1;
        repeat (2) @(posedge clk_i);
      end
    end
    // Hold data one more cycle past the last rise
    @(posedge clk_i);
    #1 host_drive = 1'b0;
  endtask : xfer_byte
  // Even number of toggles, so the level at reselect equals the level at deselect
  task automatic toggle_idle(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge clk_i);
      #1 sclk_o = ~sclk_o;
      @(posedge clk_i);
    end
  endtask : toggle_idle
endmodule : ahp_host_model

// File: tb/test_adc_serial_host_port.sv
// Self-checking bench for the serial host port
`timescale 1ns/1ps
module test_adc_serial_host_port;
  import ahp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic mode_i = 1'b0;
  logic three_wire = 1'b0;
  logic cs_n_i = 1'b1;
  logic [23:0] result_i = 24'h000000;
  logic result_load_i = 1'b0;
  logic host_sclk, sdio_wire, sclk_o, sclk_oe_n_o, sdio_o, sdio_oe_n_o, sol, sol_oe_n;
  logic data_ready_n_o;
  logic [23:0] ctrl_o, offset_o, pos_span_o, neg_span_o;
  int fail_count = 0;
  int samples_checked = 0;
  int gap = 0;
  int lead = 0;
  int long_gaps = 0;
  logic armed = 1'b0;
  logic sclk_q = 1'b1;
  logic cs_q = 1'b1;
  always #20 clk_i = ~clk_i;
  ahp_host_port dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .mode_i(mode_i), .cs_n_i(cs_n_i),
    .sclk_i(host_sclk), .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe_n_o), .sdio_i(sdio_wire),
    .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o), .serial_output_line_o(sol),
    .serial_output_line_oe_n_o(sol_oe_n), .data_ready_n_o(data_ready_n_o),
    .result_i(result_i), .result_load_i(result_load_i), .ctrl_o(ctrl_o),
    .offset_o(offset_o), .pos_span_o(pos_span_o), .neg_span_o(neg_span_o)
  );
  ahp_host_model host_u (
    .clk_i(clk_i), .mode_i(mode_i), .three_wire_i(three_wire), .dev_sclk_i(sclk_o),
    .dev_data_i(sdio_o), .dev_data_oe_n_i(sdio_oe_n_o), .sol_i(sol), .sol_oe_n_i(sol_oe_n),
    .sclk_o(host_sclk), .sdio_o(sdio_wire)
  );
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  // Generated clock timing, sampled mid-cycle where it is settled
  always @(negedge clk_i) begin
    gap++;
    lead++;
    if (mode_i && !cs_n_i && cs_q && sclk_o) begin
      lead = 0;
      armed = 1'b1;
    end
    if (armed && sclk_q && !sclk_o) begin
      chk(24'(lead), 24'(SC_LEAD_CYC + 1));
      armed = 1'b0;
    end
    if (mode_i && sclk_o && !sclk_q) begin
      if (gap == SC_RISE_RISE) begin
        long_gaps++;
      end else if (gap < SC_RISE_RISE) begin
        chk(24'(gap), 24'(SC_DIV));
      end
      gap = 0;
    end
    sclk_q = sclk_o;
    cs_q = cs_n_i;
  end
  // Instruction then n data bytes; deselects before data byte number pause
  task automatic xfer(input logic [7:0] ins, input logic [31:0] wd, input int n,
                      input int pause, output logic [31:0] rd);
    logic [7:0] b;
    int lows;
    rd = 32'h0;
    lows = 0;
    @(posedge clk_i);
    #1 cs_n_i = 1'b0;
    host_u.xfer_byte(ins, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      if (i == pause) begin
        cs_n_i = 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        chk(24'(sdio_oe_n_o & sol_oe_n), 24'h1);
        if (mode_i) begin
          repeat (60) begin
            @(posedge clk_i);
            #1;
            if (sclk_o !== 1'b1) lows++;
          end
          chk(24'(lows), 24'h0);
        end else begin
          host_u.toggle_idle(3);
          #1;
        end
        cs_n_i = 1'b0;
      end
      host_u.xfer_byte(wd[31-8*i -: 8], ins[7], b);
      rd[31-8*i -: 8] = b;
    end
    cs_n_i = 1'b1;
    repeat (40) @(posedge clk_i);
    #1;
  endtask : xfer
  initial begin
    #(40 * 30000);
    fail_count++;
    test_done();
  end
  initial begin
    logic [31:0] r;
    repeat (10) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk(ctrl_o, RST_CTRL);
    chk(offset_o, RST_OFFSET);
    chk(pos_span_o, RST_POS);
    chk(neg_span_o, RST_NEG);
    chk(24'({data_ready_n_o, sclk_oe_n_o, sclk_o}), 24'h7);
    $display("test reset done");
    xfer(8'hca, 32'ha1b2c300, 3, -1, r);
    chk(offset_o, 24'ha1b2c3);
    xfer(8'h4a, 32'h0, 3, 1, r);
    chk(r[31:8], 24'ha1b2c3);
    xfer(8'hea, 32'h01020304, 4, -1, r);
    chk(offset_o, 24'h040203);
    $display("test external two-wire done");
    xfer(8'hce, 32'h11223300, 3, -1, r);
    xfer(8'hde, 32'h44556600, 3, -1, r);
    chk(pos_span_o, 24'h112233);
    chk(neg_span_o, 24'h445566);
    xfer(8'h1e, 32'h0, 1, -1, r);
    chk(24'(r[31:24]), 24'h44);
    xfer(8'h2e, 32'h0, 2, -1, r);
    chk(24'(r[31:16]), 24'h1122);
    $display("test span done");
    result_i = 24'h123456;
    result_load_i = 1'b1;
    @(posedge clk_i);
    #1 result_load_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk(24'(data_ready_n_o), 24'h0);
    xfer(8'h82, 32'hff000000, 1, -1, r);
    xfer(8'h42, 32'h0, 3, -1, r);
    chk(r[31:8], 24'h123456);
    chk(24'(data_ready_n_o), 24'h1);
    $display("test result done");
    xfer(8'h84, 32'h05000000, 1, -1, r);
    chk(ctrl_o, 24'h000005);
    three_wire = 1'b1;
    xfer(8'h48, 32'h0, 3, -1, r);
    chk(r[31:8], 24'h030204);
    $display("test three-wire ascending done");
    mode_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk(24'(sclk_oe_n_o), 24'h0);
    xfer(8'h48, 32'h0, 3, 1, r);
    chk(r[31:8], 24'h030204);
    xfer(8'h88, 32'h5a000000, 1, -1, r);
    chk(offset_o, 24'h04025a);
    chk(24'(long_gaps > 0), 24'h1);
    $display("test self clocking done");
    test_done();
  end
endmodule : test_adc_serial_host_port
